//--- src/adcc_regs.vh
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
// register byte offsets
`define ADCC_CTRL_OFS      8'h00
`define ADCC_RES_HIGH_OFS  8'h04
`define ADCC_RES_LOW_OFS   8'h08
`define ADCC_STAT_OFS      8'h0C
`define ADCC_MASK_OFS      8'h10
`define ADCC_CMD_OFS       8'h14
`define ADCC_PINSEL_OFS    8'h18
// converter_control fields
`define ADCC_PU_BIT        7
`define ADCC_JUST_BIT      6
`define ADCC_RESOLUTION_SELECT_BIT      5
`define ADCC_SGN_BIT       4
`define ADCC_PRS_MSB       3
`define ADCC_PRS_LSB       0
`define ADCC_CTRL_RST      8'h00
// command fields
`define ADCC_CMD_START_BIT 0
`define ADCC_CMD_CONT_BIT  1
`define ADCC_CMD_CH_MSB    6
`define ADCC_CMD_CH_LSB    4
// status / mask fields
`define ADCC_ST_DONE_BIT   0
`define ADCC_ST_ABORT_BIT  1
`define ADCC_PINSEL_RST    8'h00
// timing: 10-bit conversion time at reference conversion clock
`define ADCC_CONV_TIME_NS  14000
`define ADCC_CONV_REF_KHZ  2000
`define ADCC_CONV_CLKS     ((`ADCC_CONV_TIME_NS*`ADCC_CONV_REF_KHZ)/1000000)
`define ADCC_RES_BITS      10
`define ADCC_SAMPLE_CLKS   (`ADCC_CONV_CLKS-`ADCC_RES_BITS)
// axi responses
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2
`endif

//--- src/adcc_prescaler.v
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler
(
  input  wire       clk,      // bus clock
  input  wire       resetn,   // async reset, active low
  input  wire       run,      // conversion clock allowed
  input  wire [3:0] prescale_select,      // prescale_select
  output reg        tick,     // one-cycle pulse per conversion clock
  output reg        conv_clk  // divided conversion clock
);
  reg [3:0] cnt_r;

  // period is (prs+1)*2 bus clocks; stopped and low while not running
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r    <= 4'h0;
      conv_clk <= 1'b0;
      tick     <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r    <= 4'h0;
      conv_clk <= 1'b0;
      tick     <= 1'b0;
    end
    // lowering prescale mid-count must not let the counter wrap round
    else if (cnt_r >= prescale_select)
    begin
      cnt_r    <= 4'h0;
      conv_clk <= ~conv_clk;
      tick     <= ~conv_clk;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      tick  <= 1'b0;
    end
  end
endmodule // adcc_prescaler
`default_nettype wire

//--- src/adcc_format.v
`timescale 1ns/1ps
`default_nettype none
module adcc_format
(
  input  wire [9:0] raw,      // 10-bit conversion code
  input  wire       justify,  // justify_select, 1 = right
  input  wire       resolution_select,     // resolution_select, 1 = 8-bit
  input  wire       signed_select,      // signed_select
  output reg  [7:0] high,     // result_high value
  output reg  [7:0] low       // result_low value
);
  reg [9:0] code;

  always @*
  begin
    code = raw;
    // justify bit set means sign ignored, 8-bit results included
    if (signed_select && !justify)
      code[9] = ~raw[9];
    if (resolution_select)
    begin
      high = code[9:2];
      low  = 8'h00;
    end
    else if (justify)
    begin
      high = {6'h00, code[9:8]};
      low  = code[7:0];
    end
    else
    begin
      high = code[9:2];
      low  = {code[1:0], 6'h00};
    end
  end
endmodule // adcc_format
`default_nettype wire

//--- src/adcc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.vh"
module adcc_top
(
  input  wire        clk,            // bus clock, 40 MHz
  input  wire        resetn,         // async reset, active low
  input  wire [7:0]  s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output reg         s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write strobes
  input  wire        s_axi_wvalid,   // write data valid
  output reg         s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [7:0]  s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output reg         s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  input  wire        stop_mode,      // mcu in stop mode, level
  input  wire        comp_in,        // comparator: input above dac trial
  output reg         analog_en,      // analog circuitry powered
  output wire        conv_clk,       // conversion clock to analog core
  output reg         sample_en,      // sample-and-hold tracking
  output reg  [2:0]  chan_sel,       // analog multiplexer channel
  output reg  [9:0]  dac_code,       // sar trial code
  output reg  [7:0]  pin_analog,     // per-pin analog function enable
  output reg         irq             // level interrupt
);
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV   = 3'b100;
  localparam integer SAMPLE_N  = `ADCC_SAMPLE_CLKS - 1;
  localparam [4:0] SAMPLE_LAST = SAMPLE_N[4:0];
  reg  [7:0]  ctrl_r, res_high_r, res_low_r;
  reg  [1:0]  stat_r, mask_r;
  reg         cont_r, aw_full_r, w_full_r;
  reg  [2:0]  state_r;
  reg  [4:0]  cnt_r;
  reg  [9:0]  bit_r, sar_r;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        tick, wr_go, wr_lane0, ctrl_wr, cmd_wr;
  wire        powered, abort, busy, done, rd_go, stat_rd;
  wire [9:0]  final_code;
  wire [7:0]  fmt_high, fmt_low;
  wire [1:0]  evt;
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ADCC_CTRL_OFS) || (a == `ADCC_RES_HIGH_OFS) ||
               (a == `ADCC_RES_LOW_OFS) || (a == `ADCC_STAT_OFS) ||
               (a == `ADCC_MASK_OFS) || (a == `ADCC_CMD_OFS) ||
               (a == `ADCC_PINSEL_OFS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  assign wr_go    = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_lane0 = wr_go && w_strb_r[0];
  assign ctrl_wr  = wr_lane0 && (aw_addr_r == `ADCC_CTRL_OFS);
  assign cmd_wr   = wr_lane0 && (aw_addr_r == `ADCC_CMD_OFS);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_full_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_full_r      <= 1'b0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_full_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_full_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `ADCC_RESP_OKAY
                                          : `ADCC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; all stay accessible while powered down
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r     <= `ADCC_CTRL_RST;
      mask_r     <= 2'h0;
      pin_analog <= `ADCC_PINSEL_RST;
      chan_sel   <= 3'h0;
      cont_r     <= 1'b0;
    end
    else if (wr_lane0)
    begin
      case (aw_addr_r)
        `ADCC_CTRL_OFS:   ctrl_r <= w_data_r[7:0];
        `ADCC_MASK_OFS:   mask_r <= w_data_r[1:0];
        `ADCC_PINSEL_OFS: pin_analog <= w_data_r[7:0];
        `ADCC_CMD_OFS:
        begin
          cont_r   <= w_data_r[`ADCC_CMD_CONT_BIT];
          chan_sel <= w_data_r[`ADCC_CMD_CH_MSB:`ADCC_CMD_CH_LSB];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power and conversion clock
  // stop only masks the power bit, so it comes back on exit by itself
  assign powered = ctrl_r[`ADCC_PU_BIT] && !stop_mode;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      analog_en <= 1'b0;
    else
      analog_en <= powered;
  end

  adcc_prescaler u_prescaler
  (
    .clk      (clk),
    .resetn   (resetn),
    .run      (powered),
    .prescale_select      (ctrl_r[`ADCC_PRS_MSB:`ADCC_PRS_LSB]),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // successive approximation sequencer
  assign busy  = (state_r != ST_IDLE);
  assign abort = busy && (ctrl_wr || !powered);
  assign done  = (state_r == ST_CONV) && tick && bit_r[0] && !abort;
  assign final_code = comp_in ? sar_r : (sar_r & ~bit_r);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= ST_IDLE;
      cnt_r     <= 5'h00;
      bit_r     <= 10'h000;
      sar_r     <= 10'h000;
      sample_en <= 1'b0;
      dac_code  <= 10'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // only an explicit start command launches a conversion
          if (cmd_wr && w_data_r[`ADCC_CMD_START_BIT] && powered)
          begin
            state_r   <= ST_SAMPLE;
            cnt_r     <= 5'h00;
            sample_en <= 1'b1;
          end
        end
        ST_SAMPLE:
        begin
          if (abort)
          begin
            state_r   <= ST_IDLE;
            sample_en <= 1'b0;
          end
          else if (tick)
          begin
            if (cnt_r == SAMPLE_LAST)
            begin
              state_r   <= ST_CONV;
              sample_en <= 1'b0;
              bit_r     <= 10'h200;
              sar_r     <= 10'h200;
              dac_code  <= 10'h200;
            end
            else
              cnt_r <= cnt_r + 5'h01;
          end
        end
        ST_CONV:
        begin
          if (abort)
          begin
            state_r  <= ST_IDLE;
            dac_code <= 10'h000;
          end
          else if (tick)
          begin
            if (bit_r[0])
            begin
              // continuous mode re-samples straight away
              state_r   <= cont_r ? ST_SAMPLE : ST_IDLE;
              sample_en <= cont_r;
              cnt_r     <= 5'h00;
              dac_code  <= 10'h000;
            end
            else
            begin
              bit_r    <= bit_r >> 1;
              sar_r    <= final_code | (bit_r >> 1);
              dac_code <= final_code | (bit_r >> 1);
            end
          end
        end
        default:
        begin
          state_r   <= ST_IDLE;
          sample_en <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result formatting and latching
  adcc_format u_format
  (
    .raw     (final_code),
    .justify (ctrl_r[`ADCC_JUST_BIT]),
    .resolution_select    (ctrl_r[`ADCC_RESOLUTION_SELECT_BIT]),
    .signed_select     (ctrl_r[`ADCC_SGN_BIT]),
    .high    (fmt_high),
    .low     (fmt_low)
  );

  // both bytes in the same edge so a read never mixes two conversions
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      res_high_r <= 8'h00;
      res_low_r  <= 8'h00;
    end
    else if (done)
    begin
      res_high_r <= fmt_high;
      res_low_r  <= fmt_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, status and interrupt
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_go && (s_axi_araddr == `ADCC_STAT_OFS);
  assign evt     = {abort, done};

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCC_RESP_OKAY;
      stat_r        <= 2'h0;
      irq           <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `ADCC_RESP_OKAY
                                             : `ADCC_RESP_SLVERR;
        case (s_axi_araddr)
          `ADCC_CTRL_OFS:     s_axi_rdata <= {24'h000000, ctrl_r};
          `ADCC_RES_HIGH_OFS: s_axi_rdata <= {24'h000000, res_high_r};
          `ADCC_RES_LOW_OFS:  s_axi_rdata <= {24'h000000, res_low_r};
          `ADCC_STAT_OFS:     s_axi_rdata <= {30'h00000000, stat_r};
          `ADCC_MASK_OFS:     s_axi_rdata <= {30'h00000000, mask_r};
          `ADCC_CMD_OFS:
            s_axi_rdata <= {25'h0000000, chan_sel, 2'h0, cont_r, busy};
          `ADCC_PINSEL_OFS:   s_axi_rdata <= {24'h000000, pin_analog};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // new event beats the clear-on-read in the same cycle
      stat_r <= (stat_rd ? 2'h0 : stat_r) | evt;
      irq    <= |(((stat_rd ? 2'h0 : stat_r) | evt) & mask_r);
    end
  end
endmodule // adcc_top
`default_nettype wire

//--- testbench/adcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model
(
  input  wire logic       clk,        // bus clock
  input  wire logic       analog_en,  // analog core powered
  input  wire logic [9:0] dac_code,   // sar trial code
  input  wire logic [9:0] level,      // input voltage as a code
  output wire logic       comp_in     // comparator output
);
  logic tog_r = 1'b0;
  always @(posedge clk) tog_r <= ~tog_r;
  // unpowered comparator gives junk, so a design must not trust it
  assign comp_in = analog_en ? (level >= dac_code) : tog_r;
endmodule // adcc_analog_model
`default_nettype wire

//--- testbench/adcc_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_checker
(
  input wire logic        clk,            // bus clock
  input wire logic        resetn,         // reset, active low
  input wire logic [7:0]  s_axi_awaddr,   // write address
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic [31:0] s_axi_wdata,    // write data
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        stop_mode,      // stop level
  input wire logic        analog_en,      // analog powered
  input wire logic        conv_clk,       // conversion clock
  input wire logic        sample_en,      // sampling
  input wire logic [9:0]  dac_code        // trial code
);
  logic [7:0] aw_q, wd_q;
  logic [3:0] prs_q;
  logic [5:0] cnt_r;
  logic       bv_q, cc_q, per_ok;
  wire        rise = conv_clk && !cc_q;
  wire        busy = sample_en || (dac_code != 10'h000);
  wire        ctrl_wr = s_axi_bvalid && !bv_q && (aw_q == 8'h00);
  ////////////////////////////////////////////////////////////////////////
  // period checked only inside a conversion: idle clock may be gated
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {aw_q, wd_q, prs_q, cnt_r, bv_q, cc_q, per_ok} <= 29'h0000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (ctrl_wr) prs_q <= wd_q[3:0];
      bv_q <= s_axi_bvalid;
      cc_q <= conv_clk;
      cnt_r <= rise ? 6'h01 : cnt_r + {5'h0, cnt_r != 6'h3F};
      if (ctrl_wr || !busy || !analog_en) per_ok <= 1'b0;
      else if (rise) per_ok <= 1'b1;
    end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_stop_held;
    stop_mode [*3];
  endsequence
  sequence s_pwr_on;
    ctrl_wr ##0 wd_q[7] ##1 !stop_mode [*2];
  endsequence
  a_stop_quiet: assert property (s_stop_held |->
    !analog_en && !sample_en && !conv_clk && dac_code == 10'h000)
    else $error("converter active in stop mode");
  a_exit_idle: assert property ($fell(stop_mode) |->
    (!sample_en && dac_code == 10'h000) [*3])
    else $error("conversion started on stop exit");
  a_ctrl_abort: assert property (ctrl_wr |-> ##2
    (!sample_en && dac_code == 10'h000) [*2])
    else $error("control write did not abort");
  a_power_on: assert property (s_pwr_on |-> analog_en)
    else $error("power bit set but analog off");
  a_power_off: assert property (ctrl_wr && !wd_q[7] |->
    ##3 !analog_en && !conv_clk)
    else $error("power bit clear but analog on");
  a_prescale_div: assert property (rise && per_ok |->
    cnt_r == ({2'b00, prs_q} + 6'h01) * 6'h02)
    else $error("conversion clock period wrong");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule // adcc_checker
bind adcc_top adcc_checker u_chk (.clk(clk), .resetn(resetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .stop_mode(stop_mode), .analog_en(analog_en), .conv_clk(conv_clk),
  .sample_en(sample_en), .dac_code(dac_code));
`default_nettype wire

//--- testbench/adc_control_power_format_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_power_format_bench;
  logic        clk = 1'b0, resetn = 1'b0, stop_mode = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [9:0]  level = 10'h000;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, comp_in, analog_en, conv_clk, sample_en, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   chan_sel;
  wire [9:0]   dac_code;
  wire [7:0]   pin_analog;
  int          error_cnt = 0, check_count = 0, cyc = 0;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  adcc_top DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stop_mode(stop_mode), .comp_in(comp_in), .analog_en(analog_en),
    .conv_clk(conv_clk), .sample_en(sample_en), .chan_sel(chan_sel),
    .dac_code(dac_code), .pin_analog(pin_analog), .irq(irq));
  adcc_analog_model u_ana (.clk(clk), .analog_en(analog_en),
    .dac_code(dac_code), .level(level), .comp_in(comp_in));

  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] e, g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task close_out;
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      close_out;
    end
  end
  // monitor: oldest note against each answer
  always @(posedge clk)
  begin
    if ((s_axi_rvalid & s_axi_rready) === 1'b1)
      chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if ((s_axi_bvalid & s_axi_bready) === 1'b1)
      chk("bresp", bq.pop_front(), s_axi_bresp);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] e = 2'h0);
    logic dn;
    bq.push_back(e);
    dn = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        dn = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] e = 2'h0);
    logic dn;
    rq.push_back({e, d});
    dn = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        dn = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  function automatic [15:0] fmt(input [9:0] r, input j, r8, s);
    logic [9:0] v;
    v = r;
    if (s && !j) v[9] = ~v[9];
    if (r8) fmt = {v[9:2], 8'h00};
    else if (!j) fmt = {v[9:2], v[1:0], 6'h00};
    else fmt = {6'h00, r};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    logic [7:0] p;
    logic [9:0] t;
    logic [15:0] f;
    n = $urandom(32'h5A8B);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h00, 32'h0);
    chk("analog_en", 1'b0, analog_en);
    wr(8'h10, 32'h1);
    // every justify/resolution/sign mix, prescale rising with it
    for (int i = 0; i < 8; i++)
    begin
      t = 10'($urandom);
      wr(8'h00, {24'h0, 1'b1, i[2:0], i[3:0]});
      level <= t;
      wr(8'h14, {25'h0, i[2:0], 4'h1});
      n = 0;
      while (irq !== 1'b1)
      begin
        @(posedge clk);
        n++;
      end
      chk("conv_time", 1'b1, n > 54*(i+1) && n <= 56*(i+1));
      chk("chan_sel", i[2:0], chan_sel);
      rd(8'h0C, 32'h1);
      f = fmt(t, i[2], i[1], i[0]);
      rd(8'h04, {24'h0, f[15:8]});
      rd(8'h08, {24'h0, f[7:0]});
      chk("irq", 1'b0, irq);
    end
    // abort by control write, abort bit masked
    wr(8'h14, 32'h11);
    repeat (20) @(posedge clk);
    wr(8'h00, 32'h83);
    repeat (4) @(posedge clk);
    chk("irq", 1'b0, irq);
    rd(8'h0C, 32'h2);
    repeat (600) @(posedge clk);
    rd(8'h0C, 32'h0);
    // power-down abort, registers still usable
    wr(8'h14, 32'h11);
    repeat (20) @(posedge clk);
    wr(8'h00, 32'h03);
    rd(8'h0C, 32'h2);
    p = 8'($urandom);
    wr(8'h18, {24'h0, p});
    chk("pin_analog", p, pin_analog);
    rd(8'h18, {24'h0, p});
    rd(8'h00, 32'h03);
    // stop mode in mid continuous conversion
    wr(8'h00, 32'h83);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h13);
    repeat (10) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (20) @(posedge clk);
    chk("analog_en", 1'b0, analog_en);
    stop_mode <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq", 1'b1, irq);
    rd(8'h0C, 32'h2);
    rd(8'h00, 32'h83);
    repeat (600) @(posedge clk);
    rd(8'h0C, 32'h0);
    chk("analog_en", 1'b1, analog_en);
    wr(8'h1C, 32'h5, 2'h2);
    rd(8'h1C, 32'h0, 2'h2);
    close_out;
  end
endmodule // adc_control_power_format_bench
`default_nettype wire
